/* File: src/pllcc_consts.vh */
// Purpose: Constants for the PLL clock control block
// Assumes: Byte addresses on a 32-bit register port
// Notes: Counts are in oscillator or system clock ticks
`ifndef PLLCC_CONSTS_VH
`define PLLCC_CONSTS_VH
// Register byte offsets
`define PLLCC_OFS_GCC 8'h00
`define PLLCC_OFS_GSTAT 8'h04
`define PLLCC_OFS_SYSEXC 8'h08
`define PLLCC_OFS_STATE 8'h0C
// Global clock control fields
`define PLLCC_BIT_RST_FAIL_EN 15
`define PLLCC_BIT_TMR_SEL 14
`define PLLCC_BIT_FLASH_WE 4
`define PLLCC_BIT_MULT 3
`define PLLCC_DIV_MSB 2
`define PLLCC_DIV_RESET 3'h7
`define PLLCC_MULT_RESET 1'b1
// Status fields
`define PLLCC_BIT_OSC_FAIL 1
`define PLLCC_BIT_CLK_RST 14
// Timing counts
`define PLLCC_DELAY_OSC_CYCLES 4096
`define PLLCC_EXTEND_CYCLES 8
`define PLLCC_WAIT_STATES 3
`define PLLCC_SYNC_CYCLES 2
`endif

/* File: src/pllcc_clock_control.v */
// Purpose: Clock control: start-up delay, prescaler, halt, failure reset
// Assumes: Oscillator and VCO edges arrive as one-cycle tick inputs
// Notes: All outputs are registered; reserved bits read as zero
//   The sequencer is one-hot: count, extend, run, halt and sync.
//   The delay counter advances on oscillator ticks only, so it keeps
//   counting while the system clock enable is held low.
//   The clock enable is cut on the edge that leaves extend or run,
//   so no short system clock period reaches the core.
//   A new divisor is taken only at the end of a prescaler period or while the clocks are stopped.
//   A monitor pause during the count clears the count and restarts it.
//   A failure seen in halt is ignored: the oscillator is off on purpose.
//   With the failure reset enabled, a failure re-enters the count with
//   the reset pending, so extend runs before the core is released.
//   Wait states are flagged on BUS_WAIT; the write itself never stalls.
//
// Contract
// - Failure with reset enabled causes system reset
// - Enable clear: no reset, failure flag pollable
// - Failure reset sets clock-monitor reset flag
// - Each control write inserts three wait states
// - Reserved control bits ignore writes, read zero
// - Flash config bit gates flash register writes
// - Multiplier select resets set, meaning times four
// - Prescale divisor changes without clock glitch
// - Prescale field resets to divide-by-eight
// - PLL runs once oscillator starts switching
// - Count 4096 oscillator cycles before reset release
// - Oscillator pause restarts the full delay count
// - Hold resets eight more system clock cycles
// - Halt shuts off oscillator and PLL
// - Halt exit waits full delay before clocks
// - CPU runs only without wait requests
// - Oscillator recovery repeats the halt-exit restart; the code restarts only with failure reset enabled or during the count
// - Multiplier change stops clock, clears delay counter
// - Clock restarts after 4096 counted cycles
// - Halt grounds input, opens bias, floats output
// - Bypass pin selects oscillator or gated VCO
// - Failure flag sticks until cleared or reset
`include "pllcc_consts.vh"

module pllcc_clock_control #(
  parameter DELAY_CYCLES = `PLLCC_DELAY_OSC_CYCLES,
  parameter EXTEND_CYCLES = `PLLCC_EXTEND_CYCLES,
  parameter SYNC_CYCLES = `PLLCC_SYNC_CYCLES
) (
  input wire CLOCK,
  input wire RST_N,
  input wire OSC_TICK,
  input wire VCO_TICK,
  input wire OSC_FAIL_DET,
  input wire PLL_BYPASS_PIN,
  input wire HALT_REQ,
  input wire EXT_RESET_N_IN,
  input wire WAIT_REQ,
  input wire [7:0] REG_ADDR,
  input wire [31:0] REG_WDATA,
  input wire REG_WR,
  input wire REG_RD,
  output reg [31:0] REG_RDATA,
  output reg BUS_WAIT,
  output reg SYSTEM_CLOCK_EN,
  output reg CPU_RUN,
  output reg SYS_RESET_N,
  output reg RESET_N_OUT,
  output reg MULT_SEL,
  output reg FLASH_CFG_WE,
  output reg TIMER_CLK_SEL,
  output reg OSC_ENABLE,
  output reg PLL_ENABLE,
  output reg OSC_IN_GROUND,
  output reg BIAS_OPEN,
  output reg OSC_OUT_OE_N
);

  // One-hot sequencer states
  localparam [4:0] ST_COUNT = 5'h01;
  localparam [4:0] ST_EXTEND = 5'h02;
  localparam [4:0] ST_RUN = 5'h04;
  localparam [4:0] ST_HALT = 5'h08;
  localparam [4:0] ST_SYNC = 5'h10;

  // Last values of each counter, cut to the counter width on purpose
  localparam integer DELAY_LAST_I = DELAY_CYCLES - 1;
  localparam integer EXT_LAST_I = EXTEND_CYCLES - 1;
  localparam integer SYNC_LAST_I = SYNC_CYCLES - 1;
  localparam integer WAIT_LAST_I = `PLLCC_WAIT_STATES - 1;
  localparam [12:0] DELAY_LAST = DELAY_LAST_I[12:0];
  localparam [3:0] EXT_LAST = EXT_LAST_I[3:0];
  localparam [1:0] SYNC_LAST = SYNC_LAST_I[1:0];
  localparam [1:0] WAIT_LAST = WAIT_LAST_I[1:0];

  // Sequencer state and counters
  reg [4:0] state_ff, nxt_state;
  reg [12:0] delay_cnt_ff, nxt_delay_cnt;
  reg [3:0] ext_cnt_ff, nxt_ext_cnt;
  reg [1:0] sync_cnt_ff, nxt_sync_cnt;
  reg rst_pending_ff, nxt_rst_pending;
  reg fail_reset;

  // Control register copies not seen on a port
  reg rst_fail_en_ff;
  reg [2:0] div_field_ff;

  // Prescaler divisor in use and its tick count
  reg [2:0] div_active_ff;
  reg [2:0] pre_cnt_ff;

  // Sticky status flags
  reg osc_fail_ff;
  reg clk_rst_ff;

  // Wait state counter after a control write
  reg [1:0] wait_cnt_ff;
  reg wait_busy_ff;

  // Register write decodes
  wire wr_gcc = REG_WR && (REG_ADDR == `PLLCC_OFS_GCC);
  wire wr_gstat = REG_WR && (REG_ADDR == `PLLCC_OFS_GSTAT);
  wire wr_sysexc = REG_WR && (REG_ADDR == `PLLCC_OFS_SYSEXC);
  wire mult_change = wr_gcc && (REG_WDATA[`PLLCC_BIT_MULT] != MULT_SEL);

  // One-hot state decodes
  wire in_count = state_ff[0];
  wire in_extend = state_ff[1];
  wire in_run = state_ff[2];
  wire in_halt = state_ff[3];

  // Clock enable is live only in extend and run
  wire clocks_on = in_run || in_extend;
  wire nxt_clocks_on = nxt_state[2] || nxt_state[1];

  // Prescaler source and period end
  wire src_tick = PLL_BYPASS_PIN ? OSC_TICK : (VCO_TICK && clocks_on);
  wire sys_tick = clocks_on && src_tick && (pre_cnt_ff >= div_active_ff);

  // Oscillator monitor and reset holds
  wire osc_fail_now = OSC_FAIL_DET && !in_halt;
  wire reset_hold = rst_pending_ff || !EXT_RESET_N_IN;

  // Sequencer next state
  always @* begin
    nxt_state = state_ff;
    nxt_delay_cnt = delay_cnt_ff;
    nxt_ext_cnt = ext_cnt_ff;
    nxt_sync_cnt = sync_cnt_ff;
    nxt_rst_pending = rst_pending_ff;
    fail_reset = 1'b0;
    case (state_ff)
      // Count oscillator ticks; a monitor pause restarts the count
      ST_COUNT: begin
        if (osc_fail_now) begin
          nxt_delay_cnt = 13'h0000;
        end else if (OSC_TICK) begin
          if (delay_cnt_ff == DELAY_LAST) begin
            nxt_delay_cnt = 13'h0000;
            nxt_ext_cnt = 4'h0;
            nxt_state = rst_pending_ff ? ST_EXTEND : ST_RUN;
          end else begin
            nxt_delay_cnt = delay_cnt_ff + 13'h0001;
          end
        end
      end
      // Hold resets for the extra system clock periods
      ST_EXTEND: begin
        if (sys_tick && ext_cnt_ff != EXT_LAST) begin
          nxt_ext_cnt = ext_cnt_ff + 4'h1;
        end else if (ext_cnt_ff == EXT_LAST && sys_tick && EXT_RESET_N_IN) begin
          nxt_rst_pending = 1'b0;
          nxt_state = ST_RUN;
        end
      end
      // Running: halt or a multiplier change stops the clocks
      ST_RUN: begin
        if (HALT_REQ) begin
          nxt_state = ST_HALT;
        end else if (mult_change) begin
          nxt_sync_cnt = 2'h0;
          nxt_state = ST_SYNC;
        end
      end
      // Oscillator and PLL off until the halt request drops
      ST_HALT: begin
        if (!HALT_REQ) begin
          nxt_delay_cnt = 13'h0000;
          nxt_state = ST_COUNT;
        end
      end
      // Synchronising cycles before the delay count restarts
      ST_SYNC: begin
        if (sync_cnt_ff == SYNC_LAST) begin
          nxt_delay_cnt = 13'h0000;
          nxt_state = ST_COUNT;
        end else begin
          nxt_sync_cnt = sync_cnt_ff + 2'h1;
        end
      end
      default: begin
        nxt_state = ST_COUNT;
        nxt_delay_cnt = 13'h0000;
      end
    endcase
    // Failure with reset enabled restarts as after halt
    if (osc_fail_now && rst_fail_en_ff && !in_count) begin
      fail_reset = 1'b1;
      nxt_rst_pending = 1'b1;
      nxt_delay_cnt = 13'h0000;
      nxt_state = ST_COUNT;
    end
    // A failure during the count only re-arms the reset
    if (osc_fail_now && rst_fail_en_ff && in_count) begin
      fail_reset = 1'b1;
      nxt_rst_pending = 1'b1;
    end
  end

  // Sequencer registers
  always @(posedge CLOCK) begin
    if (!RST_N) begin
      state_ff <= ST_COUNT;
      delay_cnt_ff <= 13'h0000;
      ext_cnt_ff <= 4'h0;
      sync_cnt_ff <= 2'h0;
      rst_pending_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      delay_cnt_ff <= nxt_delay_cnt;
      ext_cnt_ff <= nxt_ext_cnt;
      sync_cnt_ff <= nxt_sync_cnt;
      rst_pending_ff <= nxt_rst_pending;
    end
  end

  // Control register fields; reserved bits are dropped
  always @(posedge CLOCK) begin
    if (!RST_N) begin
      rst_fail_en_ff <= 1'b0;
      TIMER_CLK_SEL <= 1'b0;
      FLASH_CFG_WE <= 1'b0;
      MULT_SEL <= `PLLCC_MULT_RESET;
      div_field_ff <= `PLLCC_DIV_RESET;
    end else if (wr_gcc) begin
      rst_fail_en_ff <= REG_WDATA[`PLLCC_BIT_RST_FAIL_EN];
      TIMER_CLK_SEL <= REG_WDATA[`PLLCC_BIT_TMR_SEL];
      FLASH_CFG_WE <= REG_WDATA[`PLLCC_BIT_FLASH_WE];
      MULT_SEL <= REG_WDATA[`PLLCC_BIT_MULT];
      div_field_ff <= REG_WDATA[`PLLCC_DIV_MSB:0];
    end
  end

  // Three wait states after each control write
  always @(posedge CLOCK) begin
    if (!RST_N) begin
      wait_cnt_ff <= 2'h0;
      wait_busy_ff <= 1'b0;
      BUS_WAIT <= 1'b0;
    end else if (wr_gcc) begin
      wait_cnt_ff <= 2'h0;
      wait_busy_ff <= 1'b1;
      BUS_WAIT <= 1'b1;
    end else if (wait_busy_ff && wait_cnt_ff == WAIT_LAST) begin
      wait_busy_ff <= 1'b0;
      BUS_WAIT <= 1'b0;
    end else if (wait_busy_ff) begin
      wait_cnt_ff <= wait_cnt_ff + 2'h1;
    end
  end

  // Prescaler: new divisor loads at a period boundary or while the clocks are stopped
  always @(posedge CLOCK) begin
    if (!RST_N) begin
      pre_cnt_ff <= 3'h0;
      div_active_ff <= `PLLCC_DIV_RESET;
      SYSTEM_CLOCK_EN <= 1'b0;
    end else begin
      // Cut the enable on the edge that stops the clocks
      SYSTEM_CLOCK_EN <= sys_tick && nxt_clocks_on;
      // Clear the count and load the divisor while the clocks are stopped
      if (!clocks_on) begin
        pre_cnt_ff <= 3'h0;
        div_active_ff <= div_field_ff;
      end else if (sys_tick) begin
        pre_cnt_ff <= 3'h0;
        div_active_ff <= div_field_ff;
      end else if (src_tick) begin
        pre_cnt_ff <= pre_cnt_ff + 3'h1;
      end
    end
  end

  // Oscillator failure flag; a set beats a clear in the same cycle
  always @(posedge CLOCK) begin
    if (!RST_N) begin
      osc_fail_ff <= 1'b0;
    end else if (osc_fail_now) begin
      osc_fail_ff <= 1'b1;
    end else if (fail_reset || (!EXT_RESET_N_IN)) begin
      osc_fail_ff <= 1'b0;
    end else if (wr_gstat && REG_WDATA[`PLLCC_BIT_OSC_FAIL]) begin
      osc_fail_ff <= 1'b0;
    end
  end

  // Clock-monitor reset flag; a set beats a clear, cleared by writing zero
  always @(posedge CLOCK) begin
    if (!RST_N) begin
      clk_rst_ff <= 1'b0;
    end else if (fail_reset) begin
      clk_rst_ff <= 1'b1;
    end else if (wr_sysexc && !REG_WDATA[`PLLCC_BIT_CLK_RST]) begin
      clk_rst_ff <= 1'b0;
    end
  end

  // Internal and external reset outputs move together
  always @(posedge CLOCK) begin
    if (!RST_N) begin
      SYS_RESET_N <= 1'b0;
      RESET_N_OUT <= 1'b0;
    end else begin
      SYS_RESET_N <= !reset_hold;
      RESET_N_OUT <= !reset_hold;
    end
  end

  // Run enable: running state, no reset, no wait request
  always @(posedge CLOCK) begin
    if (!RST_N) begin
      CPU_RUN <= 1'b0;
    end else begin
      CPU_RUN <= in_run && !reset_hold && !WAIT_REQ;
    end
  end

  // Oscillator, PLL and pin controls follow the next state
  always @(posedge CLOCK) begin
    if (!RST_N) begin
      OSC_ENABLE <= 1'b1;
      PLL_ENABLE <= 1'b0;
      OSC_IN_GROUND <= 1'b0;
      BIAS_OPEN <= 1'b0;
      OSC_OUT_OE_N <= 1'b0;
    end else begin
      OSC_ENABLE <= !nxt_state[3];
      PLL_ENABLE <= !nxt_state[3] && !PLL_BYPASS_PIN;
      OSC_IN_GROUND <= nxt_state[3];
      BIAS_OPEN <= nxt_state[3];
      OSC_OUT_OE_N <= nxt_state[3];
    end
  end

  // Read images of each register; reserved bits read as zero
  wire [31:0] gcc_word = {16'h0000, rst_fail_en_ff, TIMER_CLK_SEL, 9'h000,
    FLASH_CFG_WE, MULT_SEL, div_field_ff};
  wire [31:0] gstat_word = {30'h00000000, osc_fail_ff, 1'b0};
  wire [31:0] sysexc_word = {17'h00000, clk_rst_ff, 14'h0000};
  wire [31:0] state_word = {11'h000, state_ff, 3'h0, delay_cnt_ff};

  // Register read port, data one cycle after the strobe
  always @(posedge CLOCK) begin
    if (!RST_N) begin
      REG_RDATA <= 32'h00000000;
    end else if (REG_RD) begin
      case (REG_ADDR)
        `PLLCC_OFS_GCC: REG_RDATA <= gcc_word;
        `PLLCC_OFS_GSTAT: REG_RDATA <= gstat_word;
        `PLLCC_OFS_SYSEXC: REG_RDATA <= sysexc_word;
        `PLLCC_OFS_STATE: REG_RDATA <= state_word;
        default: REG_RDATA <= 32'h00000000;
      endcase
    end else begin
      REG_RDATA <= 32'h00000000;
    end
  end

endmodule

/* File: tb/pllcc_chk_sva.sv */
// Purpose: Port assertions for the clock control block
// Assumes: Control register at offset 0x00
// Notes: Mirrors the failure-reset enable from bus writes
module pllcc_chk (
  input wire CLOCK,
  input wire RST_N,
  input wire [7:0] REG_ADDR,
  input wire [31:0] REG_WDATA,
  input wire REG_WR,
  input wire REG_RD,
  input wire [31:0] REG_RDATA,
  input wire BUS_WAIT,
  input wire WAIT_REQ,
  input wire CPU_RUN,
  input wire SYS_RESET_N,
  input wire RESET_N_OUT,
  input wire EXT_RESET_N_IN,
  input wire MULT_SEL,
  input wire OSC_FAIL_DET,
  input wire OSC_IN_GROUND,
  input wire OSC_OUT_OE_N,
  input wire OSC_ENABLE,
  input wire SYSTEM_CLOCK_EN
);
  reg en_ff;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  // Copy of the failure-reset enable bit
  always @(posedge CLOCK) begin
    if (!RST_N) en_ff <= 1'b0;
    else if (REG_WR && REG_ADDR == 8'h00) en_ff <= REG_WDATA[15];
  end
  a_wait_three: assert property (REG_WR && REG_ADDR == 8'h00 |=> BUS_WAIT [*3])
    else $error("bus wait not held three cycles");
  a_rsvd_zero: assert property (REG_RD && REG_ADDR == 8'h00 |=> REG_RDATA[31:16] == 16'h0000 && REG_RDATA[13:5] == 9'h000)
    else $error("reserved control bits not zero");
  a_mult_store: assert property (REG_WR && REG_ADDR == 8'h00 |=> MULT_SEL == $past(REG_WDATA[3]))
    else $error("multiplier select not stored");
  a_reset_pair: assert property (SYS_RESET_N == RESET_N_OUT)
    else $error("internal and external reset differ");
  a_ext_hold: assert property (!SYS_RESET_N && !EXT_RESET_N_IN |=> !SYS_RESET_N)
    else $error("reset released while pin held low");
  a_cpu_wait: assert property (WAIT_REQ |=> !CPU_RUN)
    else $error("cpu runs during wait request");
  a_fail_rst: assert property (en_ff && OSC_FAIL_DET && !OSC_IN_GROUND |-> ##2 !SYS_RESET_N)
    else $error("no reset on oscillator failure");
  a_halt_off: assert property (OSC_IN_GROUND |-> !OSC_ENABLE && OSC_OUT_OE_N && !SYSTEM_CLOCK_EN)
    else $error("halt left oscillator or clock running");
endmodule
bind pllcc_clock_control pllcc_chk u_chk (.CLOCK(CLOCK), .RST_N(RST_N), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .BUS_WAIT(BUS_WAIT),
  .WAIT_REQ(WAIT_REQ), .CPU_RUN(CPU_RUN), .SYS_RESET_N(SYS_RESET_N), .RESET_N_OUT(RESET_N_OUT),
  .EXT_RESET_N_IN(EXT_RESET_N_IN), .MULT_SEL(MULT_SEL), .OSC_FAIL_DET(OSC_FAIL_DET),
  .OSC_IN_GROUND(OSC_IN_GROUND), .OSC_OUT_OE_N(OSC_OUT_OE_N), .OSC_ENABLE(OSC_ENABLE), .SYSTEM_CLOCK_EN(SYSTEM_CLOCK_EN));

/* File: tb/pllcc_osc_model.sv */
// Purpose: Oscillator, VCO and clock monitor facing the block
// Assumes: Oscillator runs at half the system clock
// Notes: A pause stops the ticks and raises the monitor
module pllcc_osc_model (
  input wire CLOCK,
  input wire OSC_ENABLE,
  input wire PLL_ENABLE,
  input wire pause,
  output reg OSC_TICK,
  output wire VCO_TICK,
  output wire OSC_FAIL_DET
);
  timeunit 1ns;
  timeprecision 1ps;
  initial OSC_TICK = 1'b0;
  // Tick every other cycle while running
  always @(posedge CLOCK) OSC_TICK <= (OSC_ENABLE === 1'b1) && !pause && (OSC_TICK !== 1'b1);
  // VCO follows the oscillator, monitor flags a pause
  assign VCO_TICK = PLL_ENABLE && OSC_ENABLE && !pause;
  assign OSC_FAIL_DET = pause;
endmodule

/* File: tb/test_pll_clock_control.sv */
// Purpose: Self-checking bench for the clock control block
// Assumes: Delay count shortened to 16 oscillator ticks
// Notes: One oscillator tick every two system clocks
module test_pll_clock_control;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [31:0] wd; logic [31:0] rv; logic fl;} pllcc_row_t;
  pllcc_row_t rows [3] = '{'{32'hFFFFFFFF, 32'h0000C01F, 1'b1}, '{32'h00008008, 32'h00008008, 1'b0},
    '{32'h0000000F, 32'h0000000F, 1'b0}};
  reg CLOCK = 0, RST_N = 0, PLL_BYPASS_PIN = 0, HALT_REQ = 0, EXT_RESET_N_IN = 0, WAIT_REQ = 0;
  reg REG_WR = 0, REG_RD = 0, pause = 0;
  reg [7:0] REG_ADDR = 8'h00;
  reg [31:0] REG_WDATA = 32'h00000000;
  wire [31:0] REG_RDATA;
  wire OSC_TICK, VCO_TICK, OSC_FAIL_DET, BUS_WAIT, SYSTEM_CLOCK_EN, CPU_RUN, SYS_RESET_N, RESET_N_OUT, MULT_SEL;
  wire FLASH_CFG_WE, TIMER_CLK_SEL, OSC_ENABLE, PLL_ENABLE, OSC_IN_GROUND, BIAS_OPEN, OSC_OUT_OE_N;
  int n_fail = 0, comparisons = 0, g, d;
  always #12.5 CLOCK = ~CLOCK;
  pllcc_osc_model u_osc (.CLOCK(CLOCK), .OSC_ENABLE(OSC_ENABLE), .PLL_ENABLE(PLL_ENABLE), .pause(pause),
    .OSC_TICK(OSC_TICK), .VCO_TICK(VCO_TICK), .OSC_FAIL_DET(OSC_FAIL_DET));
  pllcc_clock_control #(.DELAY_CYCLES(16)) u_dut (.CLOCK(CLOCK), .RST_N(RST_N), .OSC_TICK(OSC_TICK),
    .VCO_TICK(VCO_TICK), .OSC_FAIL_DET(OSC_FAIL_DET), .PLL_BYPASS_PIN(PLL_BYPASS_PIN), .HALT_REQ(HALT_REQ),
    .EXT_RESET_N_IN(EXT_RESET_N_IN), .WAIT_REQ(WAIT_REQ), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .BUS_WAIT(BUS_WAIT), .SYSTEM_CLOCK_EN(SYSTEM_CLOCK_EN),
    .CPU_RUN(CPU_RUN), .SYS_RESET_N(SYS_RESET_N), .RESET_N_OUT(RESET_N_OUT), .MULT_SEL(MULT_SEL),
    .FLASH_CFG_WE(FLASH_CFG_WE), .TIMER_CLK_SEL(TIMER_CLK_SEL), .OSC_ENABLE(OSC_ENABLE),
    .PLL_ENABLE(PLL_ENABLE), .OSC_IN_GROUND(OSC_IN_GROUND), .BIAS_OPEN(BIAS_OPEN), .OSC_OUT_OE_N(OSC_OUT_OE_N));
  // Verdict and end of run
  task conclude;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task tick;
    @(posedge CLOCK);
    #1;
  endtask
  // One-cycle bus write and read
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge CLOCK);
    REG_WR <= 1'b1;
    REG_ADDR <= a;
    REG_WDATA <= v;
    @(posedge CLOCK);
    REG_WR <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge CLOCK);
    REG_RD <= 1'b1;
    REG_ADDR <= a;
    @(posedge CLOCK);
    REG_RD <= 1'b0;
    #1 chk("rdata", exp, REG_RDATA);
  endtask
  // Bounded wait for the cpu to run, n is cycles taken
  task wait_run(output int n);
    for (n = 0; CPU_RUN !== 1'b1; n++) begin
      if (n >= 3000) begin
        n_fail++;
        conclude();
      end
      tick();
    end
  endtask
  // Cycles between two clock enable pulses
  task gap(output int n);
    for (n = 0; SYSTEM_CLOCK_EN !== 1'b1 && n < 40; n++) tick();
    n = 0;
    do begin
      tick();
      n++;
    end while (SYSTEM_CLOCK_EN !== 1'b1 && n < 40);
  endtask
  // Main sequence
  initial begin
    repeat (20) @(posedge CLOCK);
    RST_N <= 1'b1;
    repeat (200) tick();
    chk("ext_hold", 32'h0, {31'h0, SYS_RESET_N});
    chk("pll_run", 32'h1, {31'h0, PLL_ENABLE});
    @(posedge CLOCK) EXT_RESET_N_IN <= 1'b1;
    wait_run(g);
    rd(8'h00, 32'h0000000F);
    rd(8'h10, 32'h00000000);
    $display("reset test done");
    foreach (rows[i]) begin
      wr(8'h00, rows[i].wd);
      rd(8'h00, rows[i].rv);
      chk("flash_we", {31'h0, rows[i].fl}, {31'h0, FLASH_CFG_WE});
    end
    for (d = 0; d < 8; d++) begin
      wr(8'h00, 32'h00000008 | 32'(d));
      repeat (3) gap(g);
      chk("divisor", 32'(d + 1), 32'(g));
    end
    @(posedge CLOCK) PLL_BYPASS_PIN <= 1'b1;
    wr(8'h00, 32'h00000009);
    repeat (3) gap(g);
    chk("bypass_div", 32'h4, 32'(g));
    chk("pll_off", 32'h0, {31'h0, PLL_ENABLE});
    @(posedge CLOCK) PLL_BYPASS_PIN <= 1'b0;
    $display("register and divisor tests done");
    @(posedge CLOCK) WAIT_REQ <= 1'b1;
    repeat (3) tick();
    chk("cpu_wait", 32'h0, {31'h0, CPU_RUN});
    @(posedge CLOCK) WAIT_REQ <= 1'b0;
    wait_run(g);
    wr(8'h00, 32'h00000007);
    repeat (5) tick();
    chk("mult_stop", 32'h0, {31'h0, CPU_RUN});
    wait_run(g);
    chk("mult_delay", 32'h1, 32'(g >= 24));
    $display("wait and multiplier tests done");
    @(posedge CLOCK) HALT_REQ <= 1'b1;
    repeat (5) tick();
    chk("halt_pins", 32'hD, {28'h0, OSC_IN_GROUND, BIAS_OPEN, OSC_ENABLE, OSC_OUT_OE_N});
    @(posedge CLOCK) HALT_REQ <= 1'b0;
    repeat (6) tick();
    @(posedge CLOCK) pause <= 1'b1;
    repeat (3) tick();
    rd(8'h0C, 32'h00010000);
    @(posedge CLOCK) pause <= 1'b0;
    wait_run(g);
    chk("halt_delay", 32'h1, 32'(g >= 24));
    wr(8'h00, 32'h00008007);
    @(posedge CLOCK) pause <= 1'b1;
    repeat (4) tick();
    chk("fail_rst", 32'h0, {31'h0, SYS_RESET_N});
    @(posedge CLOCK) pause <= 1'b0;
    wait_run(g);
    chk("fail_restart", 32'h1, 32'(g >= 90));
    rd(8'h08, 32'h00004000);
    wr(8'h08, 32'h00000000);
    rd(8'h08, 32'h00000000);
    wr(8'h00, 32'h00000007);
    @(posedge CLOCK) pause <= 1'b1;
    repeat (4) tick();
    chk("no_rst", 32'h1, {31'h0, SYS_RESET_N});
    @(posedge CLOCK) pause <= 1'b0;
    rd(8'h04, 32'h00000002);
    wr(8'h04, 32'h00000002);
    rd(8'h04, 32'h00000000);
    $display("halt and failure tests done");
    conclude();
  end
endmodule
